/* hw/jmc_pkg.sv */
// Constants, register map and types for the joystick measurement control block
package jmc_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int JMC_CLK_MHZ = 250;
  localparam int JMC_US_PER_MS = 1000;
  localparam int JMC_IRQ_DLY_US = 450;
  localparam int JMC_CYC_PER_MS = JMC_US_PER_MS * JMC_CLK_MHZ;
  localparam int JMC_IRQ_DLY_CYC = JMC_IRQ_DLY_US * JMC_CLK_MHZ;
  localparam int JMC_SOFT_RST_CYC = 4;

  // ==========================================================================
  // Register addresses seen by the serial register engine
  localparam logic [7:0] JMC_ADDR_CTRL = 8'h0f;
  localparam logic [7:0] JMC_ADDR_X = 8'h10;
  localparam logic [7:0] JMC_ADDR_Y = 8'h11;
  localparam logic [7:0] JMC_ADDR_LIM0 = 8'h12;
  localparam logic [7:0] JMC_ADDR_LIM3 = 8'h15;

  // ==========================================================================
  // Control register fields
  localparam int JMC_IDLE_BIT = 7;
  localparam int JMC_TB_HI = 6;
  localparam int JMC_TB_LO = 4;
  localparam int JMC_INTDIS_BIT = 3;
  localparam int JMC_INTSRC_BIT = 2;
  localparam int JMC_SOFT_BIT = 1;
  localparam int JMC_VALID_BIT = 0;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] JMC_CTRL_RST = 8'hf0;
  localparam logic [7:0] JMC_COORD_RST = 8'h00;
  // Left, right, top, bottom: +5, -5, +5, -5
  localparam logic [7:0] JMC_LIM_RST [0:3] = '{8'h05, 8'hfb, 8'h05, 8'hfb};

  // ==========================================================================
  // Wake-up interval table in ms: 20,40,80,100,140,200,260,320
  typedef logic [8:0] jmc_ms_t;
  localparam jmc_ms_t JMC_TB_MS [0:7] = '{9'h014, 9'h028, 9'h050, 9'h064,
                                          9'h08c, 9'h0c8, 9'h104, 9'h140};

  // ==========================================================================
  // Measurement sequencer states
  typedef enum logic [1:0] {
    JMC_M_IDLE = 2'b01,
    JMC_M_BUSY = 2'b10
  } jmc_meas_e;

endpackage : jmc_pkg

/* hw/jmc_wake_timer.sv */
// Low-power wake-up timer with selectable interval
`timescale 1ns/10ps
module jmc_wake_timer #(
  parameter int CYC_PER_MS = jmc_pkg::JMC_CYC_PER_MS
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [2:0] sel,
  output logic wake
);
  import jmc_pkg::*;

  localparam int PW = $clog2(CYC_PER_MS + 1);

  generate
    if (CYC_PER_MS < 1) begin : g_bad_div
      $error("CYC_PER_MS must be at least 1");
    end
  endgenerate

  logic [PW-1:0] pre_q;
  jmc_ms_t ms_q;
  logic ms_tick;

  // ==========================================================================
  // Millisecond enable divider
  assign ms_tick = (pre_q == PW'(CYC_PER_MS - 1));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= '0;
    end else if (!enable || ms_tick) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + PW'(1);
    end
  end

  // ==========================================================================
  // Interval count; restarts whenever low-power mode is left
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_q <= '0;
      wake <= 1'b0;
    end else if (!enable) begin
      ms_q <= '0;
      wake <= 1'b0;
    end else if (ms_tick && ms_q == JMC_TB_MS[sel] - 9'h001) begin
      ms_q <= '0;
      wake <= 1'b1;
    end else begin
      ms_q <= ms_tick ? ms_q + 9'h001 : ms_q;
      wake <= 1'b0;
    end
  end

  AST_WAKE_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
    !enable |=> !wake) else $error("Wake pulse outside low-power mode");

endmodule : jmc_wake_timer

/* hw/jmc_top.sv */
// Measurement scheduling, data-valid, interrupt and soft reset for the joystick sensor
// ============================================================================
// Overview of operation
// - Idle bit 0: low-power mode, timer-triggered measurements at selected interval.
// - Idle bit 1: measurement starts after the ACK following a Y read.
// - Interval field 6:4 selects 20,40,80,100,140,200,260,320 ms; default 320.
// - Interrupt-disable bit 3 set keeps the interrupt pin released high.
// - Source bit 0: interrupt per measurement; idle mode 450 us after Y read.
// - Interrupt clears after the ACK following a Y read.
// - Source bit 1: interrupt only when the magnet leaves the dead zone.
// - Dead-zone interrupt re-asserts at next measurement if still outside.
// - Soft reset reloads all registers; bit self-clears when sequence ends.
// - Valid bit reads 0 during conversion, 1 when fresh X and Y exist.
// - Pointer at control, X or Y freezes the valid bit, X and Y.
// - Control register resets to 1111 0000.
// - X and Y are 8-bit two's complement coordinates.
// - Four signed limits reset to +5, -5, +5, -5.
`timescale 1ns/10ps
module jmc_top #(
  parameter int CYC_PER_MS = jmc_pkg::JMC_CYC_PER_MS,
  parameter int IRQ_DLY_CYC = jmc_pkg::JMC_IRQ_DLY_CYC
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_ptr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd_ack,
  output logic [7:0] reg_rdata,
  output logic meas_start,
  input wire logic meas_done,
  input wire logic [7:0] meas_x,
  input wire logic [7:0] meas_y,
  input wire logic motion_irq_n_i,
  output logic motion_irq_n_o,
  output logic motion_irq_n_oe_n,
  output logic irq_line_low
);
  import jmc_pkg::*;

  localparam int DW = $clog2(IRQ_DLY_CYC + 1);
  localparam int SW = $clog2(JMC_SOFT_RST_CYC + 1);

  generate
    if (IRQ_DLY_CYC < 1) begin : g_bad_dly
      $error("IRQ_DLY_CYC must be at least 1");
    end
  endgenerate

  // ==========================================================================
  // Reset release
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ==========================================================================
  // Soft reset sequencer
  logic soft_busy_q;
  logic [SW-1:0] soft_cnt_q;
  logic ctrl_wr;
  logic soft_req;

  assign ctrl_wr = reg_wr && reg_ptr == JMC_ADDR_CTRL && !soft_busy_q;
  assign soft_req = ctrl_wr && reg_wdata[JMC_SOFT_BIT];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_busy_q <= 1'b0;
      soft_cnt_q <= '0;
    end else if (soft_req) begin
      soft_busy_q <= 1'b1;
      soft_cnt_q <= '0;
    end else if (soft_busy_q) begin
      soft_busy_q <= soft_cnt_q != SW'(JMC_SOFT_RST_CYC - 1);
      soft_cnt_q <= soft_cnt_q + SW'(1);
    end
  end

  // ==========================================================================
  // Control register, bits 7:2 stored here
  logic [7:2] ctrl_q;
  logic idle_mode;
  logic irq_dis;
  logic irq_src;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= JMC_CTRL_RST[7:2];
    end else if (soft_busy_q || soft_req) begin
      ctrl_q <= JMC_CTRL_RST[7:2];
    end else if (ctrl_wr) begin
      ctrl_q <= reg_wdata[7:2];
    end
  end

  assign idle_mode = ctrl_q[JMC_IDLE_BIT];
  assign irq_dis = ctrl_q[JMC_INTDIS_BIT];
  assign irq_src = ctrl_q[JMC_INTSRC_BIT];

  // ==========================================================================
  // Dead-zone limits: left, right, top, bottom
  logic [7:0] lim_q [0:3];
  logic [7:0] lim_idx;

  assign lim_idx = reg_ptr - JMC_ADDR_LIM0;

  for (genvar i = 0; i < 4; i++) begin : g_lim
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        lim_q[i] <= JMC_LIM_RST[i];
      end else if (soft_busy_q) begin
        lim_q[i] <= JMC_LIM_RST[i];
      end else if (reg_wr && lim_idx == 8'(i)) begin
        lim_q[i] <= reg_wdata;
      end
    end
  end

  logic signed [7:0] left_limit;
  logic signed [7:0] right_limit;
  logic signed [7:0] top_limit;
  logic signed [7:0] bottom_limit;
  logic outside;

  assign left_limit = lim_q[0];
  assign right_limit = lim_q[1];
  assign top_limit = lim_q[2];
  assign bottom_limit = lim_q[3];
  // Positive X is toward the left
  assign outside = $signed(meas_x) > left_limit || $signed(meas_x) < right_limit ||
                   $signed(meas_y) > top_limit || $signed(meas_y) < bottom_limit;

  // ==========================================================================
  // Measurement sequencer
  jmc_meas_e state_q;
  logic wake;
  logic y_ack;
  logic start_req;
  logic done_evt;

  jmc_wake_timer #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_wake (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .enable(!idle_mode && !soft_busy_q),
    .sel(ctrl_q[JMC_TB_HI:JMC_TB_LO]),
    .wake(wake)
  );

  assign y_ack = reg_rd_ack && reg_ptr == JMC_ADDR_Y;
  // A Y read restarts conversion even mid-measurement; a wake while busy is dropped
  assign start_req = !soft_busy_q && ((idle_mode && y_ack) ||
                     (!idle_mode && wake && state_q == JMC_M_IDLE));
  assign done_evt = meas_done && state_q == JMC_M_BUSY;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= JMC_M_IDLE;
    end else if (soft_busy_q) begin
      state_q <= JMC_M_IDLE;
    end else begin
      case (state_q)
        JMC_M_IDLE: state_q <= start_req ? JMC_M_BUSY : JMC_M_IDLE;
        JMC_M_BUSY: state_q <= (meas_done && !start_req) ? JMC_M_IDLE : JMC_M_BUSY;
        default: state_q <= JMC_M_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meas_start <= 1'b0;
    end else begin
      meas_start <= start_req;
    end
  end

  // ==========================================================================
  // Coordinates: fresh sample, then frozen-aware visible copy
  logic [7:0] x_new_q;
  logic [7:0] y_new_q;
  logic valid_raw_q;
  logic [7:0] x_q;
  logic [7:0] y_q;
  logic valid_q;
  logic frozen;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      x_new_q <= JMC_COORD_RST;
      y_new_q <= JMC_COORD_RST;
      valid_raw_q <= 1'b0;
    end else if (soft_busy_q) begin
      x_new_q <= JMC_COORD_RST;
      y_new_q <= JMC_COORD_RST;
      valid_raw_q <= 1'b0;
    end else if (start_req) begin
      valid_raw_q <= 1'b0;
    end else if (done_evt) begin
      x_new_q <= meas_x;
      y_new_q <= meas_y;
      valid_raw_q <= 1'b1;
    end
  end

  // Keeps valid bit, X and Y taken together while the host reads them
  assign frozen = reg_ptr == JMC_ADDR_CTRL || reg_ptr == JMC_ADDR_X || reg_ptr == JMC_ADDR_Y;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      x_q <= JMC_COORD_RST;
      y_q <= JMC_COORD_RST;
      valid_q <= 1'b0;
    end else if (soft_busy_q) begin
      x_q <= JMC_COORD_RST;
      y_q <= JMC_COORD_RST;
      valid_q <= 1'b0;
    end else if (!frozen) begin
      x_q <= x_new_q;
      y_q <= y_new_q;
      valid_q <= valid_raw_q;
    end
  end

  // ==========================================================================
  // Idle-mode interrupt delay after Y readout
  logic dly_run_q;
  logic [DW-1:0] dly_cnt_q;
  logic dly_fire;

  assign dly_fire = dly_run_q && dly_cnt_q == DW'(IRQ_DLY_CYC - 1);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dly_run_q <= 1'b0;
      dly_cnt_q <= '0;
    end else if (soft_busy_q) begin
      dly_run_q <= 1'b0;
      dly_cnt_q <= '0;
    end else if (y_ack && idle_mode && !irq_src) begin
      dly_run_q <= 1'b1;
      dly_cnt_q <= '0;
    end else if (dly_run_q) begin
      dly_run_q <= !dly_fire;
      dly_cnt_q <= dly_cnt_q + DW'(1);
    end
  end

  // ==========================================================================
  // Interrupt flag and open-drain pin
  logic irq_q;
  logic set_any;
  logic [1:0] pin_sync_q;

  assign set_any = (done_evt && !irq_src && !idle_mode) ||
                   (dly_fire && !irq_src) ||
                   (done_evt && irq_src && outside);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else if (soft_busy_q) begin
      irq_q <= 1'b0;
    end else if (set_any) begin
      irq_q <= 1'b1;
    end else if (y_ack) begin
      irq_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      motion_irq_n_oe_n <= 1'b1;
    end else begin
      motion_irq_n_oe_n <= !(irq_q && !irq_dis);
    end
  end
  assign motion_irq_n_o = 1'b0;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync_q <= 2'b11;
    end else begin
      pin_sync_q <= {pin_sync_q[0], motion_irq_n_i};
    end
  end
  assign irq_line_low = !pin_sync_q[1];

  // ==========================================================================
  // Read data; unmapped addresses return zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_ptr == JMC_ADDR_CTRL) begin
      reg_rdata <= {ctrl_q, soft_busy_q, valid_q};
    end else if (reg_ptr == JMC_ADDR_X) begin
      reg_rdata <= x_q;
    end else if (reg_ptr == JMC_ADDR_Y) begin
      reg_rdata <= y_q;
    end else if (reg_ptr >= JMC_ADDR_LIM0 && reg_ptr <= JMC_ADDR_LIM3) begin
      reg_rdata <= lim_q[lim_idx[1:0]];
    end else begin
      reg_rdata <= '0;
    end
  end

  // ==========================================================================
  // Checks
  AST_SOFT_RELOAD: assert property (@(posedge core_clk) disable iff (!rst_n)
    soft_req |=> soft_busy_q ##1 (ctrl_q == JMC_CTRL_RST[7:2] && !irq_q)[*3] ##1 !soft_busy_q)
    else $error("Soft reset sequence wrong");

  AST_Y_START: assert property (@(posedge core_clk) disable iff (!rst_n)
    (y_ack && idle_mode && !soft_busy_q) |=> meas_start)
    else $error("Y read did not start a measurement");

  AST_WAKE_START: assert property (@(posedge core_clk) disable iff (!rst_n)
    (meas_start && !$past(idle_mode)) |-> $past(wake)) else $error("Low-power start without wake");

  AST_PIN_DISABLED: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(irq_dis) |-> motion_irq_n_oe_n) else $error("Interrupt driven while disabled");

  AST_Y_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_n)
    (y_ack && !set_any) |=> !irq_q ##1 (motion_irq_n_oe_n || $past(set_any)))
    else $error("Interrupt not cleared by Y read");

  AST_DZ_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
    (done_evt && irq_src && outside && !soft_busy_q) |=> irq_q ##1 (motion_irq_n_oe_n == irq_dis))
    else $error("Dead-zone exit did not raise interrupt");

  AST_DZ_QUIET: assert property (@(posedge core_clk) disable iff (!rst_n)
    (irq_src && !irq_q && !(done_evt && outside)) |=> !irq_q)
    else $error("Dead-zone interrupt without exit");

  AST_IDLE_DELAY: assert property (@(posedge core_clk) disable iff (!rst_n)
    (dly_fire && !irq_src && !soft_busy_q) |=> irq_q) else $error("Delayed interrupt missing");

  AST_VALID_LOW: assert property (@(posedge core_clk) disable iff (!rst_n)
    start_req |=> !valid_raw_q) else $error("Valid bit stays set in conversion");

  AST_FREEZE: assert property (@(posedge core_clk) disable iff (!rst_n)
    (frozen && !soft_busy_q) |=> ($stable(x_q) && $stable(y_q) && $stable(valid_q)))
    else $error("Coordinates changed while frozen");

endmodule : jmc_top

/* verif/jmc_front_model.sv */
// Behavioural measurement front end and interrupt pin pull-up
`timescale 1ns/10ps
module jmc_front_model (
  input wire logic core_clk,
  input wire logic meas_start,
  input wire logic [7:0] dly,
  input wire logic [7:0] x_in,
  input wire logic [7:0] y_in,
  output logic meas_done,
  output logic [7:0] meas_x,
  output logic [7:0] meas_y,
  input wire logic irq_o,
  input wire logic irq_oe_n,
  output logic irq_pin
);
  int cnt = 0;
  logic [7:0] last_x = 8'h00;
  logic [7:0] last_y = 8'h00;

  initial begin
    meas_done = 1'b0;
    meas_x = 8'h00;
    meas_y = 8'h00;
  end

  // ==========================================================================
  // Conversion timing; a new start restarts the count
  always @(posedge core_clk) begin
    if (meas_start) begin
      cnt <= int'(dly);
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
    if (!meas_start && cnt == 1) begin
      meas_done <= 1'b1;
      meas_x <= x_in;
      meas_y <= y_in;
      last_x <= x_in;
      last_y <= y_in;
    end else begin
      // Coordinates not held outside the done cycle
      meas_done <= 1'b0;
      meas_x <= ~last_x;
      meas_y <= ~last_y;
    end
  end

  // ==========================================================================
  // Open-drain line with pull-up
  assign irq_pin = irq_oe_n ? 1'b1 : irq_o;
endmodule : jmc_front_model

/* verif/tb_top.sv */
// Self-checking bench for the joystick measurement control block
`timescale 1ns/10ps
module tb_top;
  import jmc_pkg::*;
  localparam int CPM = 10;
  localparam int IDC = 20;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_ptr = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd_ack = 1'b0;
  logic [7:0] reg_rdata;
  logic meas_start, meas_done, irq_o, irq_oe_n, irq_pin, line_low;
  logic [7:0] meas_x, meas_y;
  logic [7:0] fx = 8'h00;
  logic [7:0] fy = 8'h00;
  logic [7:0] fdly = 8'h03;
  logic [7:0] old_x;
  logic smp = 1'b0;
  logic [17:0] q[$];
  logic [17:0] ent;
  logic [15:0] gap_q = 16'h0000;
  logic [15:0] gcnt = 16'h0000;
  logic [31:0] rnd = 32'hc5e44cd1;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  int ms_tab[8] = '{20, 40, 80, 100, 140, 200, 260, 320};
  logic [7:0] lim[4] = '{8'h05, 8'hfb, 8'h05, 8'hfb};
  logic [7:0] dz_x[6] = '{8'h05, 8'h00, 8'h06, 8'hfa, 8'h00, 8'h00};
  logic [7:0] dz_y[6] = '{8'h00, 8'hfb, 8'h00, 8'h00, 8'h06, 8'hfa};
  logic [15:0] dz_e[6] = '{16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

  initial begin
    forever #2 core_clk = ~core_clk;
  end

  jmc_top #(.CYC_PER_MS(CPM), .IRQ_DLY_CYC(IDC)) dut (
    .core_clk(core_clk), .arst_n(arst_n), .reg_ptr(reg_ptr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd_ack(reg_rd_ack), .reg_rdata(reg_rdata),
    .meas_start(meas_start), .meas_done(meas_done), .meas_x(meas_x), .meas_y(meas_y),
    .motion_irq_n_i(irq_pin), .motion_irq_n_o(irq_o), .motion_irq_n_oe_n(irq_oe_n),
    .irq_line_low(line_low)
  );

  jmc_front_model fe (
    .core_clk(core_clk), .meas_start(meas_start), .dly(fdly), .x_in(fx), .y_in(fy),
    .meas_done(meas_done), .meas_x(meas_x), .meas_y(meas_y), .irq_o(irq_o),
    .irq_oe_n(irq_oe_n), .irq_pin(irq_pin)
  );

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic results;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  task automatic note(input logic [1:0] kind, input logic [15:0] exp);
    q.push_back({kind, exp});
    smp = 1'b1;
    @(negedge core_clk);
    smp = 1'b0;
  endtask : note

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_ptr = a;
    reg_wr = 1'b1;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    reg_ptr = a;
    repeat (2) @(negedge core_clk);
    note(2'd0, {8'h00, exp});
  endtask : rd

  task automatic ack_y;
    @(negedge core_clk);
    reg_ptr = JMC_ADDR_Y;
    reg_rd_ack = 1'b1;
    @(negedge core_clk);
    reg_rd_ack = 1'b0;
  endtask : ack_y

  task automatic wait_start;
    int i;
    i = 0;
    @(posedge core_clk);
    while (meas_start !== 1'b1 && i < 4000) begin
      @(posedge core_clk);
      i++;
    end
  endtask : wait_start

  // ==========================================================================
  // Monitor: oldest note against what the outputs show
  always @(posedge core_clk) begin
    if (smp) begin
      ent = q.pop_front();
      case (ent[17:16])
        2'd0: check({8'h00, reg_rdata}, ent[15:0]);
        2'd1: check({15'h0000, irq_oe_n}, ent[15:0]);
        2'd2: check(gap_q, ent[15:0]);
        default: check({15'h0000, line_low}, ent[15:0]);
      endcase
    end
  end

  // Cycles between start pulses
  always @(posedge core_clk) begin
    if (meas_start === 1'b1) begin
      gap_q <= gcnt;
      gcnt <= 16'h0001;
    end else begin
      gcnt <= gcnt + 16'h0001;
    end
  end

  // Hang guard, generous over the low-power sweep
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      results();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (10) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    rd(JMC_ADDR_CTRL, 8'hf0);
    rd(JMC_ADDR_X, 8'h00);
    rd(8'h20, 8'h00);
    wr(JMC_ADDR_X, 8'h55);
    rd(JMC_ADDR_X, 8'h00);
    wr(JMC_ADDR_CTRL, 8'hf1);
    rd(JMC_ADDR_CTRL, 8'hf0);
    for (int i = 0; i < 4; i++) begin
      rd(8'h12 + 8'(i), lim[i]);
      rnd = lfsr(rnd);
      wr(8'h12 + 8'(i), rnd[7:0]);
      rd(8'h12 + 8'(i), rnd[7:0]);
      wr(8'h12 + 8'(i), lim[i]);
    end
    // Idle-mode conversion with random coordinates
    rnd = lfsr(rnd);
    fx = rnd[7:0];
    fy = rnd[15:8];
    ack_y();
    rd(8'h20, 8'h00);
    repeat (6) @(negedge core_clk);
    rd(JMC_ADDR_CTRL, 8'hf1);
    rd(JMC_ADDR_X, fx);
    rd(JMC_ADDR_Y, fy);
    // Pointer kept in the frozen set across a new conversion
    old_x = fx;
    fx = 8'h7f;
    fy = 8'h80;
    ack_y();
    repeat (8) @(negedge core_clk);
    rd(JMC_ADDR_CTRL, 8'hf1);
    rd(JMC_ADDR_X, old_x);
    rd(8'h20, 8'h00);
    rd(JMC_ADDR_X, 8'h7f);
    rd(JMC_ADDR_Y, 8'h80);
    // Slow conversion: valid low meanwhile
    fdly = 8'd40;
    ack_y();
    rd(8'h20, 8'h00);
    rd(JMC_ADDR_CTRL, 8'hf0);
    repeat (45) @(negedge core_clk);
    rd(8'h20, 8'h00);
    rd(JMC_ADDR_CTRL, 8'hf1);
    fdly = 8'd3;
    // Per-measurement interrupt, delayed after the Y read
    ack_y();
    repeat (3) @(negedge core_clk);
    note(2'd1, 16'h0001);
    repeat (7) @(negedge core_clk);
    note(2'd1, 16'h0001);
    repeat (15) @(negedge core_clk);
    note(2'd1, 16'h0000);
    // Output disabled while the flag is still tracked
    wr(JMC_ADDR_CTRL, 8'hf8);
    ack_y();
    repeat (30) @(negedge core_clk);
    note(2'd1, 16'h0001);
    wr(JMC_ADDR_CTRL, 8'hf0);
    repeat (3) @(negedge core_clk);
    note(2'd1, 16'h0000);
    // Dead zone: edges inside, one step beyond outside, repeat while outside
    wr(JMC_ADDR_CTRL, 8'hf4);
    for (int i = 0; i < 6; i++) begin
      fx = dz_x[i];
      fy = dz_y[i];
      ack_y();
      repeat (10) @(negedge core_clk);
      note(2'd1, dz_e[i]);
    end
    // Soft reset reloads everything
    wr(8'h12, 8'h33);
    wr(JMC_ADDR_CTRL, 8'h02);
    repeat (8) @(negedge core_clk);
    rd(8'h20, 8'h00);
    rd(JMC_ADDR_CTRL, 8'hf0);
    rd(8'h12, 8'h05);
    rd(JMC_ADDR_X, 8'h00);
    // Low-power sweep over every interval code
    for (int t = 0; t < 8; t++) begin
      wr(JMC_ADDR_CTRL, 8'hf0);
      wr(JMC_ADDR_CTRL, {1'b0, 3'(t), 4'h0});
      wait_start();
      // Clear the first wake's flag so the second one is seen fresh
      repeat (8) @(negedge core_clk);
      ack_y();
      repeat (4) @(negedge core_clk);
      note(2'd3, 16'h0000);
      wait_start();
      @(negedge core_clk);
      note(2'd2, 16'(ms_tab[t] * CPM));
      repeat (8) @(negedge core_clk);
      note(2'd1, 16'h0000);
      note(2'd3, 16'h0001);
    end
    // Dead zone polled by the wake timer, the pairing advised to the host
    fx = 8'h00;
    fy = 8'h00;
    wr(JMC_ADDR_CTRL, 8'hf0);
    wr(JMC_ADDR_CTRL, 8'h04);
    ack_y();
    wait_start();
    repeat (10) @(negedge core_clk);
    note(2'd3, 16'h0000);
    fx = 8'h06;
    wait_start();
    repeat (10) @(negedge core_clk);
    note(2'd3, 16'h0001);
    results();
  end
endmodule : tb_top
